// File: rtl/irq_arbiter_map.svh
/*
 * Constants of the vectored interrupt arbiter: vector addresses, source
 * bit positions, level codes and widths.
 * Assumes inclusion by the package and the design files by bare name.
 */
`ifndef IRQ_ARBITER_MAP_SVH
`define IRQ_ARBITER_MAP_SVH

// Counts
`define NUM_SOURCES     19
`define NUM_VECTORS     10
`define VEC_ADDR_W      17
`define VEC_IDX_W       4

// Vector addresses, ascending order is also grant order inside a level
`define VEC_ADDR_0      17'h00003
`define VEC_ADDR_1      17'h0000B
`define VEC_ADDR_2      17'h00013
`define VEC_ADDR_3      17'h0001B
`define VEC_ADDR_4      17'h00023
`define VEC_ADDR_5      17'h0002B
`define VEC_ADDR_6      17'h00033
`define VEC_ADDR_7      17'h0003B
`define VEC_ADDR_8      17'h00043
`define VEC_ADDR_9      17'h0004B

// Source bit positions in the request vector
`define SRC_EXT_A       0
`define SRC_EXT_B       1
`define SRC_EXT_C       2
`define SRC_T0_LOW      3
`define SRC_EXT_E       4
`define SRC_EXT_D       5
`define SRC_BASE_TIMER  6
`define SRC_T0_HIGH     7
`define SRC_T1_LOW      8
`define SRC_T1_HIGH     9
`define SRC_SYNC_A      10
`define SRC_ASYNC_RX    11
`define SRC_SYNC_B      12
`define SRC_ASYNC_TX    13
`define SRC_CONV_DONE   14
`define SRC_TIMER_SIX   15
`define SRC_TIMER_SEVEN 16
`define SRC_PWM_A       17
`define SRC_PWM_B       18

// Level codes: none, low, high, highest
`define LVL_NONE        2'h0
`define LVL_LOW         2'h1
`define LVL_HIGH        2'h2
`define LVL_TOP         2'h3

// Depth of the service level stack (three levels nest at most)
`define NEST_DEPTH      3

`endif

// File: rtl/irq_arbiter_pkg.sv
/*
 * Types shared by the interrupt arbiter files.
 * Assumes irq_arbiter_map.svh is on the include path.
 */
`include "irq_arbiter_map.svh"

package irq_arbiter_pkg;

  // Two-bit priority level
  typedef logic [1:0] level_t;

  // Handshake state of the arbiter towards the core
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_OFFER   = 3'b010,
    ST_SERVICE = 3'b100
  } arb_state_e;

endpackage : irq_arbiter_pkg

// File: rtl/multilevel_vectored_interrupt_arbiter.sv
/*
 * Multilevel vectored interrupt arbiter: gathers nineteen sources onto
 * ten vectors, picks by level then by smallest vector, and offers the
 * vector to the core; keeps a stack of service levels for nesting.
 * Assumes the core pulses irq_ack to take the offer and irq_return on
 * return from service; sources are synchronous to clk.
 * The core must clear a source before returning, or it is offered again
 * as soon as its level is above the restored one.
 */
// Notes on behaviour
// - Nineteen sources gathered onto ten shared vectors.
// - Three levels: highest above high above low.
// - Refuse requests not above the level in service.
// - Simultaneous requests: highest level granted first.
// - Equal level: smallest vector address wins.
// - Vectors 03H and 0BH: highest or low only.
// - Third, fifth external, timer zero low share 13H.
// - Serial channels share 33H and 3BH.
// - Converter, timers, pulse share 43H; port zero 4BH.
// - Fourth external, time base share 1BH; timers 23H, 2BH.
`timescale 1ns/1ns
`default_nettype none
`include "irq_arbiter_map.svh"

module multilevel_vectored_interrupt_arbiter
  import irq_arbiter_pkg::*;
#(
  parameter int NSRC = `NUM_SOURCES, // Source count
  parameter int NVEC = `NUM_VECTORS  // Vector count
) (
  input  wire logic                   clk,          // System clock, 20 MHz
  input  wire logic                   resetn,       // Synchronous reset, low
  input  wire logic [NSRC-1:0]        src_req,      // Source request levels
  input  wire logic                   port_zero_req,// Port 0 request level
  input  wire logic [2*NVEC-1:0]      level_sel,    // Two level bits per vector
  input  wire logic                   irq_ack,      // Core takes the offer
  input  wire logic                   irq_return,   // Core returns from service
  output logic                        irq_req,      // Offer to the core
  output logic [`VEC_ADDR_W-1:0]      irq_vector,   // Offered vector address
  output logic [`VEC_IDX_W-1:0]       irq_index,    // Offered vector number
  output logic [1:0]                  irq_level,    // Offered level
  output logic [1:0]                  svc_level     // Level now in service
);

  // Timing towards the core, by rising edge:
  //   edge 0          a source above the service level is sampled
  //   after edge 0    irq_req high with the winner's vector, number, level
  //   edge n          irq_ack sampled high while irq_req stands: accepted
  //   after edge n    irq_req low, svc_level shows the accepted level
  //   after edge n+1  irq_req still low while the state returns to idle
  //   after edge n+2  earliest next offer

  // Vector address lookup, ascending
  localparam logic [`VEC_ADDR_W-1:0] VEC_ADDR [0:`NUM_VECTORS-1] = '{
    `VEC_ADDR_0, `VEC_ADDR_1, `VEC_ADDR_2, `VEC_ADDR_3, `VEC_ADDR_4,
    `VEC_ADDR_5, `VEC_ADDR_6, `VEC_ADDR_7, `VEC_ADDR_8, `VEC_ADDR_9};

  // Per vector pending and clipped level
  logic   [NVEC-1:0] vpend;     // Pending per vector
  level_t            vlvl [NVEC]; // Effective level per vector

  // Source groups per vector
  wire [0:0] g0 = src_req[`SRC_EXT_A];
  wire [0:0] g1 = src_req[`SRC_EXT_B];
  wire [2:0] g2 = {src_req[`SRC_EXT_C], src_req[`SRC_T0_LOW],
                   src_req[`SRC_EXT_E]};
  wire [1:0] g3 = {src_req[`SRC_EXT_D], src_req[`SRC_BASE_TIMER]};
  wire [0:0] g4 = src_req[`SRC_T0_HIGH];
  wire [1:0] g5 = {src_req[`SRC_T1_LOW], src_req[`SRC_T1_HIGH]};
  wire [1:0] g6 = {src_req[`SRC_SYNC_A], src_req[`SRC_ASYNC_RX]};
  wire [1:0] g7 = {src_req[`SRC_SYNC_B], src_req[`SRC_ASYNC_TX]};
  wire [4:0] g8 = {src_req[`SRC_CONV_DONE], src_req[`SRC_TIMER_SIX],
                   src_req[`SRC_TIMER_SEVEN], src_req[`SRC_PWM_A],
                   src_req[`SRC_PWM_B]};
  wire [0:0] g9 = port_zero_req;

  // Each slot ORs its sources and clips the selected level, so a vector
  // that may not use the highest level can never outrank a top-two vector set to highest
  // Slots, two with highest allowed, rest high or low
  vector_slot #(.SRC_W(1), .TOP_OK(1'b1)) u_s0 (.src(g0), .level_sel(level_sel[1:0]),
    .pend(vpend[0]), .level_eff(vlvl[0]));
  vector_slot #(.SRC_W(1), .TOP_OK(1'b1)) u_s1 (.src(g1), .level_sel(level_sel[3:2]),
    .pend(vpend[1]), .level_eff(vlvl[1]));
  vector_slot #(.SRC_W(3), .TOP_OK(1'b0)) u_s2 (.src(g2), .level_sel(level_sel[5:4]),
    .pend(vpend[2]), .level_eff(vlvl[2]));
  vector_slot #(.SRC_W(2), .TOP_OK(1'b0)) u_s3 (.src(g3), .level_sel(level_sel[7:6]),
    .pend(vpend[3]), .level_eff(vlvl[3]));
  vector_slot #(.SRC_W(1), .TOP_OK(1'b0)) u_s4 (.src(g4), .level_sel(level_sel[9:8]),
    .pend(vpend[4]), .level_eff(vlvl[4]));
  vector_slot #(.SRC_W(2), .TOP_OK(1'b0)) u_s5 (.src(g5), .level_sel(level_sel[11:10]),
    .pend(vpend[5]), .level_eff(vlvl[5]));
  vector_slot #(.SRC_W(2), .TOP_OK(1'b0)) u_s6 (.src(g6), .level_sel(level_sel[13:12]),
    .pend(vpend[6]), .level_eff(vlvl[6]));
  vector_slot #(.SRC_W(2), .TOP_OK(1'b0)) u_s7 (.src(g7), .level_sel(level_sel[15:14]),
    .pend(vpend[7]), .level_eff(vlvl[7]));
  vector_slot #(.SRC_W(5), .TOP_OK(1'b0)) u_s8 (.src(g8), .level_sel(level_sel[17:16]),
    .pend(vpend[8]), .level_eff(vlvl[8]));
  vector_slot #(.SRC_W(1), .TOP_OK(1'b0)) u_s9 (.src(g9), .level_sel(level_sel[19:18]),
    .pend(vpend[9]), .level_eff(vlvl[9]));

  // Handshake with the core, one offer at a time:
  //   idle    - nothing above the service level is pending
  //   offer   - irq_req high, the vector tracks the best winner
  //   service - one cycle after an accept while the new level settles
  // The level accepted is the registered irq_level, the one the core saw,
  // not a better winner that may have appeared in the same cycle.

  // State and service level stack
  arb_state_e             state_r, state_nxt;     // Handshake state
  level_t                 stack_r [`NEST_DEPTH];  // Saved service levels
  logic   [1:0]           depth_r;                // Entries in the stack
  level_t                 cur_r;                  // Level in service

  // Winner search: scan from the highest vector down so the smallest
  // address of the best level is the last to overwrite
  level_t                 best_lvl;               // Best level found
  logic [`VEC_IDX_W-1:0]  best_idx;               // Its vector number
  always_comb begin
    best_lvl = `LVL_NONE;
    best_idx = '0;
    for (int i = NVEC-1; i >= 0; i--) begin
      // Only levels above the service level compete
      if (vpend[i] && vlvl[i] > cur_r && vlvl[i] >= best_lvl) begin
        best_lvl = vlvl[i];
        best_idx = i[`VEC_IDX_W-1:0];
      end
    end
  end

  // A candidate exists when a level above service was found
  wire found = (best_lvl != `LVL_NONE);
  // An ack outside the offer state is ignored, so a stray pulse from
  // the core cannot raise the service level to an unseen offer
  wire take  = (state_r == ST_OFFER) && irq_ack;           // Core accepts
  // A return with nothing in service is ignored
  wire ret   = irq_return && (depth_r != 2'h0);            // Valid return
  wire [1:0] depth_dec = depth_r - 2'h1;                   // Top of stack
  wire [1:0] depth_inc = depth_r + 2'h1;                   // Depth after a push

  // Push and pop never act together: an accept in the same cycle as a
  // return wins, and the core has to repeat that return
  wire         push     = take;                            // Save and raise
  wire         pop      = ret && !take;                    // Restore saved
  wire level_t restored = stack_r[depth_dec];              // Level to go back to

  // Next offer contents
  wire                   req_nxt = found && (state_nxt == ST_OFFER); // Offer stands
  wire [`VEC_ADDR_W-1:0] vec_nxt = VEC_ADDR[best_idx];    // Winner's address

  // State transitions
  always_comb begin
    state_nxt = state_r;                                   // Hold by default
    case (state_r)
      ST_IDLE: begin
        if (found) state_nxt = ST_OFFER;                   // Something to offer
      end
      ST_OFFER: begin
        if (take) state_nxt = ST_SERVICE;                  // Core accepted
        else if (!found) state_nxt = ST_IDLE;              // Winner withdrawn
      end
      ST_SERVICE: begin
        state_nxt = ST_IDLE;                               // New level settles
      end
      default: begin
        state_nxt = ST_IDLE;                               // Recover from bad code
      end
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (!resetn) state_r <= ST_IDLE;                       // Idle after reset
    else state_r <= state_nxt;
  end

  // Offer outputs follow the current winner while offering; the vector
  // may move to a better winner until the core accepts
  always_ff @(posedge clk) begin
    if (!resetn) begin
      irq_req    <= 1'b0;
      irq_vector <= '0;
      irq_index  <= '0;
      irq_level  <= `LVL_NONE;
    end else begin
      irq_req    <= req_nxt;
      irq_vector <= vec_nxt;
      irq_index  <= best_idx;
      irq_level  <= best_lvl;
    end
  end

  // Nesting: each accept pushes the level it interrupts and raises the
  // service level; each return pops it back. Every accept needs a level
  // strictly above the one in service, so the stack never overflows.

  // Level in service, used by the winner search
  always_ff @(posedge clk) begin
    if (!resetn) cur_r <= `LVL_NONE;                       // Nothing in service
    else if (push) cur_r <= irq_level;
    else if (pop) cur_r <= restored;
  end

  // Stack depth
  always_ff @(posedge clk) begin
    if (!resetn) depth_r <= 2'h0;                          // Empty stack
    else if (push) depth_r <= depth_inc;                   // One more level
    else if (pop) depth_r <= depth_dec;                    // One level less
  end

  // Saved levels: the interrupted level goes on top
  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int k = 0; k < `NEST_DEPTH; k++) stack_r[k] <= `LVL_NONE;
    end else if (push) begin
      stack_r[depth_r] <= cur_r;
    end
  end

  // Service level seen by the core, a copy of the internal level so the
  // output comes straight from its own flip-flop
  always_ff @(posedge clk) begin
    if (!resetn) svc_level <= `LVL_NONE;                   // Nothing in service
    else if (push) svc_level <= irq_level;
    else if (pop) svc_level <= restored;
  end

endmodule : multilevel_vectored_interrupt_arbiter

`default_nettype wire

// File: rtl/vector_slot.sv
/*
 * One vector slot: ORs the sources sharing a vector and clips the
 * requested level to the levels allowed for that vector.
 * Assumes sources are level requests held until the core clears them.
 */
`timescale 1ns/1ns
`default_nettype none
`include "irq_arbiter_map.svh"

module vector_slot
  import irq_arbiter_pkg::*;
#(
  parameter int              SRC_W   = 1,   // Sources sharing this vector
  parameter logic            TOP_OK  = 1'b0 // Vector may use the highest level
) (
  input  wire logic [SRC_W-1:0] src,       // Source requests of this vector
  input  wire level_t           level_sel, // Software selected level
  output var  logic             pend,      // Any source requesting
  output var  level_t           level_eff  // Level after clipping
);

  // Allowed level: highest only for the two top vectors, else high or low
  wire level_t clipped = (level_sel == `LVL_TOP && !TOP_OK) ? `LVL_HIGH :
                         (level_sel == `LVL_HIGH && TOP_OK) ? `LVL_LOW :
                         (level_sel == `LVL_NONE) ? `LVL_LOW : level_sel;

  // Shared vector requests when any member requests
  assign pend      = |src;
  assign level_eff = clipped;

endmodule : vector_slot

`default_nettype wire

// File: test/core_model.sv
/* Core side model: takes offers when allowed, returns on command.
   Drives pulses 1 ns after the clock edge. */
`timescale 1ns/1ns
`default_nettype none
module core_model (
  input  wire logic clk,       // Clock
  input  wire logic irq_req,   // Offer from arbiter
  input  wire logic take,      // Bench lets the core take
  output var  logic irq_ack,   // Take pulse
  output var  logic irq_return // Return pulse
);
  initial irq_ack = 1'b0;
  initial irq_return = 1'b0;
  // Ack only a standing offer, held one cycle
  always @(posedge clk) begin
    #1;
    irq_ack = take && irq_req && !irq_ack;
  end
  // One cycle return pulse
  task automatic do_return;
    @(posedge clk);
    #1 irq_return = 1'b1;
    @(posedge clk);
    #1 irq_return = 1'b0;
  endtask : do_return
endmodule : core_model
`default_nettype wire

// File: test/irq_arbiter_monitor.sv
/* Port checker of the interrupt arbiter.
   Bound to every arbiter instance; sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
module irq_arbiter_monitor #(parameter int NSRC = 19, parameter int NVEC = 10) (
  input wire logic              clk,           // Clock
  input wire logic              resetn,        // Reset, low
  input wire logic [NSRC-1:0]   src_req,       // Sources
  input wire logic              port_zero_req, // Port 0 source
  input wire logic [2*NVEC-1:0] level_sel,     // Levels
  input wire logic              irq_ack,       // Take pulse
  input wire logic              irq_return,    // Return pulse
  input wire logic              irq_req,       // Offer
  input wire logic [16:0]       irq_vector,    // Vector address
  input wire logic [3:0]        irq_index,     // Vector number
  input wire logic [1:0]        irq_level,     // Offer level
  input wire logic [1:0]        svc_level      // Service level
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire logic taken = irq_ack && irq_req; // Offer accepted
  property p_above; irq_req |-> irq_level > svc_level; endproperty
  property p_addr; irq_req |-> irq_vector == {10'h0, irq_index, 3'h3}; endproperty
  property p_count; irq_req |-> irq_index < 4'hA; endproperty
  property p_top; irq_req && irq_level == 2'h3 |-> irq_index < 4'h2; endproperty
  property p_nonzero; irq_req |-> irq_level != 2'h0; endproperty
  property p_take; taken |=> svc_level == $past(irq_level); endproperty
  property p_drop; taken |=> !irq_req [*2]; endproperty
  property p_back; irq_return && svc_level != 2'h0 |=> svc_level < $past(svc_level); endproperty
  property p_hold; !taken && !irq_return |=> $stable(svc_level); endproperty
  a_above: assert property (p_above)
    else $error("offer not above service level");
  a_addr: assert property (p_addr)
    else $error("vector address does not match number");
  a_count: assert property (p_count)
    else $error("vector number out of range");
  a_top: assert property (p_top)
    else $error("highest level on a vector not allowed it");
  a_nonzero: assert property (p_nonzero)
    else $error("offer without a level");
  a_take: assert property (p_take)
    else $error("service level not taken from offer");
  a_drop: assert property (p_drop)
    else $error("offer not withdrawn after take");
  a_back: assert property (p_back)
    else $error("return did not lower service level");
  a_hold: assert property (p_hold)
    else $error("service level moved without cause");
  c_take: cover property (taken);
  c_top: cover property (irq_req && irq_level == 2'h3);
  c_back: cover property (irq_return && svc_level == 2'h3);
endmodule : irq_arbiter_monitor
bind multilevel_vectored_interrupt_arbiter irq_arbiter_monitor #(.NSRC(NSRC), .NVEC(NVEC))
  i_irq_arbiter_monitor (.clk(clk), .resetn(resetn), .src_req(src_req),
  .port_zero_req(port_zero_req), .level_sel(level_sel), .irq_ack(irq_ack),
  .irq_return(irq_return), .irq_req(irq_req), .irq_vector(irq_vector),
  .irq_index(irq_index), .irq_level(irq_level), .svc_level(svc_level));
`default_nettype wire

// File: test/tb.sv
/* Testbench of the interrupt arbiter: reset, vector map, priority, nesting.
   Assumes core_model as the core and the bound checker. */
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk = 1'b0, resetn = 1'b0, port_zero_req = 1'b0, take = 1'b0;
  logic [18:0] src_req = '0;        // Sources
  logic [19:0] level_sel = '0;      // Levels
  logic irq_ack, irq_return, irq_req;
  logic [16:0] irq_vector;
  logic [3:0]  irq_index;
  logic [1:0]  irq_level, svc_level;
  int failures = 0, n_checks = 0, cycles = 0;
  logic [3:0] vtab [20] = '{4'h0, 4'h1, 4'h2, 4'h2, 4'h2, 4'h3, 4'h3, 4'h4, 4'h5, 4'h5,
                            4'h6, 4'h6, 4'h7, 4'h7, 4'h8, 4'h8, 4'h8, 4'h8, 4'h8, 4'h9};
  always #25 clk = ~clk;
  multilevel_vectored_interrupt_arbiter i_multilevel_vectored_interrupt_arbiter (
    .clk(clk), .resetn(resetn), .src_req(src_req), .port_zero_req(port_zero_req),
    .level_sel(level_sel), .irq_ack(irq_ack), .irq_return(irq_return), .irq_req(irq_req),
    .irq_vector(irq_vector), .irq_index(irq_index), .irq_level(irq_level),
    .svc_level(svc_level));
  core_model i_core_model (.clk(clk), .irq_req(irq_req), .take(take), .irq_ack(irq_ack),
    .irq_return(irq_return));
  task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic step(input int n);
    repeat (n) begin
      @(posedge clk);
      #2;
    end
  endtask : step
  task automatic wait_req;
    int k;
    k = 0;
    while (irq_req !== 1'b1 && k < 10) begin
      step(1);
      k++;
    end
  endtask : wait_req
  // Present one request set from idle and judge the offer
  task automatic offer(input logic [18:0] s, input logic pz, input logic [19:0] ls,
                       input logic [3:0] ix, input logic [1:0] lv);
    src_req = '0;
    port_zero_req = 1'b0;
    step(3);
    level_sel = ls;
    src_req = s;
    port_zero_req = pz;
    wait_req();
    chk("irq_index", 17'(ix), 17'(irq_index));
    chk("irq_vector", {10'h0, ix, 3'h3}, irq_vector);
    chk("irq_level", 17'(lv), 17'(irq_level));
  endtask : offer
  // Take the offer, clear the source, return
  task automatic serve(input logic [1:0] lv);
    take = 1'b1;
    step(2);
    take = 1'b0;
    src_req = '0;
    port_zero_req = 1'b0;
    chk("svc_level", 17'(lv), 17'(svc_level));
    i_core_model.do_return();
    step(1);
    chk("svc_level", 17'h0, 17'(svc_level));
  endtask : serve
  task automatic t_map;
    for (int i = 0; i < 20; i++) begin
      offer(i < 19 ? 19'h1 << i : 19'h0, i == 19, 20'h55555, vtab[i], 2'h1);
      serve(2'h1);
    end
    $display("test map done");
  endtask : t_map
  task automatic t_prio;
    offer(19'h02002, 1'b0, 20'h59555, 4'h7, 2'h2);
    offer(19'h01400, 1'b0, 20'h55555, 4'h6, 2'h1);
    offer(19'h00001, 1'b0, 20'h55556, 4'h0, 2'h1);
    offer(19'h00004, 1'b0, 20'h55575, 4'h2, 2'h2);
    offer(19'h00080, 1'b0, 20'h00000, 4'h4, 2'h1);
    $display("test priority done");
  endtask : t_prio
  task automatic t_nest;
    offer(19'h00080, 1'b0, 20'h55667, 4'h4, 2'h2);
    take = 1'b1;
    step(2);
    take = 1'b0;
    src_req = 19'h00004;
    step(6);
    chk("irq_req", 17'h0, 17'(irq_req));
    src_req[0] = 1'b1;
    wait_req();
    chk("irq_level", 17'h3, 17'(irq_level));
    take = 1'b1;
    step(2);
    take = 1'b0;
    src_req[0] = 1'b0;
    chk("svc_level", 17'h3, 17'(svc_level));
    i_core_model.do_return();
    step(4);
    chk("svc_level", 17'h2, 17'(svc_level));
    chk("irq_req", 17'h0, 17'(irq_req));
    i_core_model.do_return();
    step(4);
    chk("irq_index", 17'h2, 17'(irq_index));
    chk("irq_level", 17'h2, 17'(irq_level));
    src_req = '0;
    $display("test nesting done");
  endtask : t_nest
  // Cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      print_verdict();
    end
  end
  initial begin
    step(20);
    resetn = 1'b1;
    step(1);
    chk("svc_level", 17'h0, 17'(svc_level));
    t_map();
    t_prio();
    t_nest();
    print_verdict();
  end
endmodule : tb
`default_nettype wire
